/* File: cbr_pkg.sv */
// Constants, register indices and state layout for the banked CPU register file
package cbr_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W  = 5;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned WIDE_W  = 20;
  localparam int unsigned BUS_W   = 32;
  localparam int unsigned NUM_DATA = 4;
  localparam int unsigned NUM_ADDR = 2;
  localparam int unsigned NUM_BANK = 2;
  localparam int unsigned NUM_ARCH = 13;

  // ---------------------------------------------------------------
  // Register indices on the register port
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_DATA_REG_0      = 5'h00;
  localparam logic [4:0] IDX_DATA_REG_1      = 5'h01;
  localparam logic [4:0] IDX_DATA_REG_2      = 5'h02;
  localparam logic [4:0] IDX_DATA_REG_3      = 5'h03;
  localparam logic [4:0] IDX_ADDR_REG_0      = 5'h04;
  localparam logic [4:0] IDX_ADDR_REG_1      = 5'h05;
  localparam logic [4:0] IDX_FRAME_BASE      = 5'h06;
  localparam logic [4:0] IDX_VECTOR_BASE     = 5'h07;
  localparam logic [4:0] IDX_PROGRAM_COUNTER = 5'h08;
  localparam logic [4:0] IDX_USER_SP         = 5'h09;
  localparam logic [4:0] IDX_INTERRUPT_SP    = 5'h0a;
  localparam logic [4:0] IDX_STATIC_BASE     = 5'h0b;
  localparam logic [4:0] IDX_CPU_FLAGS       = 5'h0c;
  localparam logic [4:0] IDX_ACTIVE_SP       = 5'h0d;
  localparam logic [4:0] IDX_DATA_0_HIGH     = 5'h10;
  localparam logic [4:0] IDX_DATA_0_LOW      = 5'h11;
  localparam logic [4:0] IDX_DATA_1_HIGH     = 5'h12;
  localparam logic [4:0] IDX_DATA_1_LOW      = 5'h13;
  localparam logic [4:0] IDX_DATA_PAIR_LOW   = 5'h14;
  localparam logic [4:0] IDX_DATA_PAIR_HIGH  = 5'h15;
  localparam logic [4:0] IDX_ADDR_PAIR       = 5'h16;

  // ---------------------------------------------------------------
  // Flag bits held here
  // ---------------------------------------------------------------
  localparam int unsigned FLG_BANK_BIT  = 4;
  localparam int unsigned FLG_STACK_BIT = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [19:0] RST_WIDE  = 20'h0_0000;
  localparam logic [31:0] RST_BUS   = 32'h0000_0000;
  localparam logic        RST_BANK  = 1'b0;
  localparam logic        RST_STACK = 1'b0;

  // ---------------------------------------------------------------
  // Whole state of the register file
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0][3:0][15:0] data;
    logic [1:0][1:0][15:0] addr;
    logic [1:0][15:0]      fb;
    logic [19:0]           vtb;
    logic [19:0]           pc;
    logic [15:0]           user_stack_pointer;
    logic [15:0]           interrupt_stack_pointer;
    logic [15:0]           sb;
    logic                  bank;
    logic                  stk_sel;
    logic [31:0]           rdata;
    logic [15:0]           act_sp;
    logic [15:0]           cur_fb;
    logic [31:0]           cur_apair;
  } cbr_state_t;

endpackage

/* File: cbr_regfile.sv */
// Banked CPU register file: data, address, frame, vector, PC, stack and static base
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Thirteen architectural registers are visible to one program context.
// - Data, address and frame base registers form a bank, held twice.
// - Four 16-bit data registers, readable and writable as operands.
// - Data registers zero and one split into independent high and low bytes.
// - Data two over zero, three over one form 32-bit pairs.
// - Two 16-bit address registers, driven out as addressing bases and operands.
// - Address register one over zero forms a 32-bit address pair.
// - A 16-bit frame base supplies frame-relative addressing.
// - A 20-bit vector table base holds the interrupt table start.
// - A 20-bit program counter holds the next instruction address.
// - Separate 16-bit user and interrupt stack pointers.
// - The stack-select flag picks the active stack pointer.
// - A 16-bit static base supplies static-base-relative addressing.
// - Device reset puts every register into its reset state.
// - Bank flag 0 routes banked accesses to bank zero, 1 to bank one.
module cbr_regfile
  import cbr_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic        pc_step_in,
  input  wire logic [2:0]  pc_inc_in,
  input  wire logic        sp_adj_in,
  input  wire logic [15:0] sp_delta_in,
  output logic      [31:0] reg_rdata_out,
  output logic             bank_sel_out,
  output logic             stack_sel_out,
  output logic      [19:0] program_counter_out,
  output logic      [19:0] vector_table_base_out,
  output logic      [15:0] active_sp_out,
  output logic      [15:0] frame_base_out,
  output logic      [15:0] static_base_out,
  output logic      [31:0] addr_pair_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cbr_state_t st_q;
  cbr_state_t st_d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Replace one byte of a word, keeping the other half intact
  function automatic logic [15:0] put_byte(
    input logic [15:0] word,
    input logic        high,
    input logic [7:0]  val
  );
    logic [15:0] res;
    res = word;
    if (high) begin
      res[15:8] = val;
    end else begin
      res[7:0] = val;
    end
    return res;
  endfunction

  // Pick the stack pointer the flag names
  function automatic logic [15:0] pick_sp(
    input logic        sel,
    input logic [15:0] user_stack_pointer,
    input logic [15:0] interrupt_stack_pointer
  );
    return sel ? user_stack_pointer : interrupt_stack_pointer;
  endfunction

  // Read view of every index, banked ones through the current bank
  function automatic logic [31:0] read_reg(
    input cbr_state_t  s,
    input logic [4:0]  idx
  );
    logic [31:0] res;
    logic        b;
    res = RST_BUS;
    b   = s.bank;
    case (idx)
      IDX_DATA_REG_0: begin
        res[15:0] = s.data[b][0];
      end
      IDX_DATA_REG_1: begin
        res[15:0] = s.data[b][1];
      end
      IDX_DATA_REG_2: begin
        res[15:0] = s.data[b][2];
      end
      IDX_DATA_REG_3: begin
        res[15:0] = s.data[b][3];
      end
      IDX_ADDR_REG_0: begin
        res[15:0] = s.addr[b][0];
      end
      IDX_ADDR_REG_1: begin
        res[15:0] = s.addr[b][1];
      end
      IDX_FRAME_BASE: begin
        res[15:0] = s.fb[b];
      end
      IDX_VECTOR_BASE: begin
        res[19:0] = s.vtb;
      end
      IDX_PROGRAM_COUNTER: begin
        res[19:0] = s.pc;
      end
      IDX_USER_SP: begin
        res[15:0] = s.user_stack_pointer;
      end
      IDX_INTERRUPT_SP: begin
        res[15:0] = s.interrupt_stack_pointer;
      end
      IDX_STATIC_BASE: begin
        res[15:0] = s.sb;
      end
      IDX_CPU_FLAGS: begin
        res[FLG_BANK_BIT]  = s.bank;
        res[FLG_STACK_BIT] = s.stk_sel;
      end
      IDX_ACTIVE_SP: begin
        res[15:0] = pick_sp(s.stk_sel, s.user_stack_pointer, s.interrupt_stack_pointer);
      end
      IDX_DATA_0_HIGH: begin
        res[7:0] = s.data[b][0][15:8];
      end
      IDX_DATA_0_LOW: begin
        res[7:0] = s.data[b][0][7:0];
      end
      IDX_DATA_1_HIGH: begin
        res[7:0] = s.data[b][1][15:8];
      end
      IDX_DATA_1_LOW: begin
        res[7:0] = s.data[b][1][7:0];
      end
      IDX_DATA_PAIR_LOW: begin
        res = {s.data[b][2], s.data[b][0]};
      end
      IDX_DATA_PAIR_HIGH: begin
        res = {s.data[b][3], s.data[b][1]};
      end
      IDX_ADDR_PAIR: begin
        res = {s.addr[b][1], s.addr[b][0]};
      end
      default: begin
        res = RST_BUS;
      end
    endcase
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        b;
    logic [15:0] w16;
    logic [7:0]  w8;
    b   = st_q.bank;
    w16 = reg_wdata_in[15:0];
    w8  = reg_wdata_in[7:0];
    st_d = st_q;
    // Read data stand only in the cycle after the strobe
    st_d.rdata = RST_BUS;
    if (reg_rd_in) begin
      st_d.rdata = read_reg(st_q, reg_addr_in);
    end
    // Sequencing updates; a register write in the same cycle wins
    if (pc_step_in) begin
      st_d.pc = st_q.pc + {17'h0_0000, pc_inc_in};
    end
    if (sp_adj_in) begin
      if (st_q.stk_sel) begin
        st_d.user_stack_pointer = st_q.user_stack_pointer + sp_delta_in;
      end else begin
        st_d.interrupt_stack_pointer = st_q.interrupt_stack_pointer + sp_delta_in;
      end
    end
    // Only the selected bank is written; the other holds
    if (reg_wr_in) begin
      case (reg_addr_in)
        IDX_DATA_REG_0: begin
          st_d.data[b][0] = w16;
        end
        IDX_DATA_REG_1: begin
          st_d.data[b][1] = w16;
        end
        IDX_DATA_REG_2: begin
          st_d.data[b][2] = w16;
        end
        IDX_DATA_REG_3: begin
          st_d.data[b][3] = w16;
        end
        IDX_ADDR_REG_0: begin
          st_d.addr[b][0] = w16;
        end
        IDX_ADDR_REG_1: begin
          st_d.addr[b][1] = w16;
        end
        IDX_FRAME_BASE: begin
          st_d.fb[b] = w16;
        end
        IDX_VECTOR_BASE: begin
          st_d.vtb = reg_wdata_in[19:0];
        end
        IDX_PROGRAM_COUNTER: begin
          st_d.pc = reg_wdata_in[19:0];
        end
        IDX_USER_SP: begin
          st_d.user_stack_pointer = w16;
        end
        IDX_INTERRUPT_SP: begin
          st_d.interrupt_stack_pointer = w16;
        end
        IDX_STATIC_BASE: begin
          st_d.sb = w16;
        end
        IDX_CPU_FLAGS: begin
          // Bank change seen by the next access, not this one
          st_d.bank    = reg_wdata_in[FLG_BANK_BIT];
          st_d.stk_sel = reg_wdata_in[FLG_STACK_BIT];
        end
        IDX_ACTIVE_SP: begin
          if (st_q.stk_sel) begin
            st_d.user_stack_pointer = w16;
          end else begin
            st_d.interrupt_stack_pointer = w16;
          end
        end
        IDX_DATA_0_HIGH: begin
          st_d.data[b][0] = put_byte(st_q.data[b][0], 1'b1, w8);
        end
        IDX_DATA_0_LOW: begin
          st_d.data[b][0] = put_byte(st_q.data[b][0], 1'b0, w8);
        end
        IDX_DATA_1_HIGH: begin
          st_d.data[b][1] = put_byte(st_q.data[b][1], 1'b1, w8);
        end
        IDX_DATA_1_LOW: begin
          st_d.data[b][1] = put_byte(st_q.data[b][1], 1'b0, w8);
        end
        IDX_DATA_PAIR_LOW: begin
          st_d.data[b][2] = reg_wdata_in[31:16];
          st_d.data[b][0] = w16;
        end
        IDX_DATA_PAIR_HIGH: begin
          st_d.data[b][3] = reg_wdata_in[31:16];
          st_d.data[b][1] = w16;
        end
        IDX_ADDR_PAIR: begin
          st_d.addr[b][1] = reg_wdata_in[31:16];
          st_d.addr[b][0] = w16;
        end
        default: begin
          // Unmapped index: write dropped
          st_d.bank = st_q.bank;
        end
      endcase
    end
    // Registered views so every output leaves a flip-flop
    st_d.act_sp    = pick_sp(st_d.stk_sel, st_d.user_stack_pointer, st_d.interrupt_stack_pointer);
    st_d.cur_fb    = st_d.fb[st_d.bank];
    st_d.cur_apair = {st_d.addr[st_d.bank][1], st_d.addr[st_d.bank][0]};
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q.data      <= '0;
      st_q.addr      <= '0;
      st_q.fb        <= '0;
      st_q.vtb       <= RST_WIDE;
      st_q.pc        <= RST_WIDE;
      st_q.user_stack_pointer       <= RST_WORD;
      st_q.interrupt_stack_pointer       <= RST_WORD;
      st_q.sb        <= RST_WORD;
      st_q.bank      <= RST_BANK;
      st_q.stk_sel   <= RST_STACK;
      st_q.rdata     <= RST_BUS;
      st_q.act_sp    <= RST_WORD;
      st_q.cur_fb    <= RST_WORD;
      st_q.cur_apair <= RST_BUS;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out         = st_q.rdata;
  assign bank_sel_out          = st_q.bank;
  assign stack_sel_out         = st_q.stk_sel;
  assign program_counter_out   = st_q.pc;
  assign vector_table_base_out = st_q.vtb;
  assign active_sp_out         = st_q.act_sp;
  assign frame_base_out        = st_q.cur_fb;
  assign static_base_out       = st_q.sb;
  assign addr_pair_out         = st_q.cur_apair;

endmodule // cbr_regfile

`default_nettype wire

/* File: cbr_regfile_chk.sv */
// Port-level assertion checker for the banked CPU register file
`timescale 1ns/1ps
`default_nettype none
module cbr_regfile_chk
  import cbr_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic [4:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic        pc_step_in,
  input wire logic [2:0]  pc_inc_in,
  input wire logic        sp_adj_in,
  input wire logic [15:0] sp_delta_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        bank_sel_out,
  input wire logic        stack_sel_out,
  input wire logic [19:0] program_counter_out,
  input wire logic [15:0] active_sp_out,
  input wire logic [15:0] frame_base_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_flag_wr;
    reg_wr_in && reg_addr_in == IDX_CPU_FLAGS;
  endsequence
  sequence s_flag_rd;
    reg_rd_in && reg_addr_in == IDX_CPU_FLAGS;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_rd_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
    else $error("read data not zero outside a read");
  chk_flag_write: assert property (s_flag_wr |=> bank_sel_out == $past(reg_wdata_in[4])
    && stack_sel_out == $past(reg_wdata_in[7]))
    else $error("flag write not applied");
  chk_flag_hold: assert property (!(reg_wr_in && reg_addr_in == IDX_CPU_FLAGS)
    |=> $stable(bank_sel_out) && $stable(stack_sel_out))
    else $error("flags changed without a write");
  chk_flag_read: assert property (s_flag_rd |=> reg_rdata_out ==
    {24'h00_0000, stack_sel_out, 2'h0, bank_sel_out, 4'h0})
    else $error("flag read mismatch");
  chk_pc_step: assert property (pc_step_in && !reg_wr_in |=>
    program_counter_out == $past(program_counter_out) + 20'($past(pc_inc_in)))
    else $error("program counter step wrong");
  chk_pc_hold: assert property (!pc_step_in && !reg_wr_in |=> $stable(program_counter_out))
    else $error("program counter moved unasked");
  chk_sp_adjust: assert property (sp_adj_in && !reg_wr_in |=>
    active_sp_out == $past(active_sp_out) + $past(sp_delta_in))
    else $error("stack pointer adjust wrong");
  chk_fb_write: assert property (reg_wr_in && reg_addr_in == IDX_FRAME_BASE |=>
    frame_base_out == $past(reg_wdata_in[15:0]))
    else $error("frame base write not seen");
endmodule // cbr_regfile_chk

bind cbr_regfile cbr_regfile_chk u_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .pc_step_in(pc_step_in), .pc_inc_in(pc_inc_in), .sp_adj_in(sp_adj_in),
  .sp_delta_in(sp_delta_in), .reg_rdata_out(reg_rdata_out), .bank_sel_out(bank_sel_out),
  .stack_sel_out(stack_sel_out), .program_counter_out(program_counter_out),
  .active_sp_out(active_sp_out), .frame_base_out(frame_base_out)
);
`default_nettype wire

/* File: cbr_regfile_tb.sv */
// Self-checking bench for the banked CPU register file
`timescale 1ns/1ps
`default_nettype none
module cbr_regfile_tb
  import cbr_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [4:0]  reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        pc_step_in = 1'b0;
  logic [2:0]  pc_inc_in = '0;
  logic        sp_adj_in = 1'b0;
  logic [15:0] sp_delta_in = '0;
  logic [31:0] reg_rdata_out, addr_pair_out, pexp, k;
  logic        bank_sel_out, stack_sel_out, bk, sk, pend, run;
  logic [19:0] program_counter_out, vector_table_base_out, vtb, pc;
  logic [15:0] active_sp_out, frame_base_out, static_base_out, user_stack_pointer, interrupt_stack_pointer, sb;
  logic [15:0] dm[2][4], am[2][2], fbm[2];
  int          err_count, checks, seed;

  always #5 clk_sys_in = ~clk_sys_in;

  cbr_regfile u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .pc_step_in(pc_step_in), .pc_inc_in(pc_inc_in), .sp_adj_in(sp_adj_in),
    .sp_delta_in(sp_delta_in), .reg_rdata_out(reg_rdata_out), .bank_sel_out(bank_sel_out),
    .stack_sel_out(stack_sel_out), .program_counter_out(program_counter_out),
    .vector_table_base_out(vector_table_base_out), .active_sp_out(active_sp_out),
    .frame_base_out(frame_base_out), .static_base_out(static_base_out),
    .addr_pair_out(addr_pair_out)
  );

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  task automatic mreset();
    dm = '{default: '0};
    am = '{default: '0};
    fbm = '{default: '0};
    {vtb, pc, user_stack_pointer, interrupt_stack_pointer, sb, bk, sk} = '0;
  endtask

  function automatic logic [31:0] mrd(input logic [4:0] i);
    case (i)
      5'h00, 5'h01, 5'h02, 5'h03: return 32'(dm[bk][i[1:0]]);
      IDX_ADDR_REG_0, IDX_ADDR_REG_1: return 32'(am[bk][i[0]]);
      IDX_FRAME_BASE: return 32'(fbm[bk]);
      IDX_VECTOR_BASE: return 32'(vtb);
      IDX_PROGRAM_COUNTER: return 32'(pc);
      IDX_USER_SP: return 32'(user_stack_pointer);
      IDX_INTERRUPT_SP: return 32'(interrupt_stack_pointer);
      IDX_STATIC_BASE: return 32'(sb);
      IDX_CPU_FLAGS: return {24'h00_0000, sk, 2'h0, bk, 4'h0};
      IDX_ACTIVE_SP: return 32'(sk ? user_stack_pointer : interrupt_stack_pointer);
      IDX_DATA_0_HIGH, IDX_DATA_1_HIGH: return 32'(dm[bk][i[1]][15:8]);
      IDX_DATA_0_LOW, IDX_DATA_1_LOW: return 32'(dm[bk][i[1]][7:0]);
      IDX_DATA_PAIR_LOW, IDX_DATA_PAIR_HIGH: return {dm[bk][{1'b1, i[0]}], dm[bk][{1'b0, i[0]}]};
      IDX_ADDR_PAIR: return {am[bk][1], am[bk][0]};
      default: return '0;
    endcase
  endfunction

  task automatic mwr(input logic [4:0] i, input logic [31:0] d);
    case (i)
      5'h00, 5'h01, 5'h02, 5'h03: dm[bk][i[1:0]] = d[15:0];
      IDX_ADDR_REG_0, IDX_ADDR_REG_1: am[bk][i[0]] = d[15:0];
      IDX_FRAME_BASE: fbm[bk] = d[15:0];
      IDX_VECTOR_BASE: vtb = d[19:0];
      IDX_PROGRAM_COUNTER: pc = d[19:0];
      IDX_USER_SP: user_stack_pointer = d[15:0];
      IDX_INTERRUPT_SP: interrupt_stack_pointer = d[15:0];
      IDX_STATIC_BASE: sb = d[15:0];
      IDX_CPU_FLAGS: {sk, bk} = {d[7], d[4]};
      IDX_ACTIVE_SP: {user_stack_pointer, interrupt_stack_pointer} = sk ? {d[15:0], interrupt_stack_pointer} : {user_stack_pointer, d[15:0]};
      IDX_DATA_0_HIGH, IDX_DATA_1_HIGH: dm[bk][i[1]][15:8] = d[7:0];
      IDX_DATA_0_LOW, IDX_DATA_1_LOW: dm[bk][i[1]][7:0] = d[7:0];
      IDX_DATA_PAIR_LOW, IDX_DATA_PAIR_HIGH: {dm[bk][{1'b1, i[0]}], dm[bk][{1'b0, i[0]}]} = d;
      IDX_ADDR_PAIR: {am[bk][1], am[bk][0]} = d;
      default: ;
    endcase
  endtask

  // ------------------------------------------------------------
  // Drivers and comparison
  // ------------------------------------------------------------
  // One cycle of traffic; sequencing pulses only in cycles without a write
  task automatic op(input logic w, input logic r, input logic [4:0] i, input logic [31:0] d);
    logic        ps, sa;
    logic [2:0]  inc;
    logic [15:0] dl;
    ps = !w & 1'($random(seed));
    sa = !w & 1'($random(seed));
    inc = 3'($random(seed));
    dl = 16'($random(seed));
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= i;
    reg_wdata_in <= d;
    pc_step_in <= ps;
    pc_inc_in <= inc;
    sp_adj_in <= sa;
    sp_delta_in <= dl;
    @(posedge clk_sys_in);
    pexp = mrd(i);
    pend = r & !rst_in;
    if (rst_in) mreset();
    else begin
      if (w) mwr(i, d);
      if (ps) pc = pc + 20'(inc);
      if (sa && sk) user_stack_pointer = user_stack_pointer + dl;
      if (sa && !sk) interrupt_stack_pointer = interrupt_stack_pointer + dl;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  always @(negedge clk_sys_in) begin
    if (run) begin
      chk(reg_rdata_out, pend ? pexp : 32'h0000_0000);
      chk(32'(program_counter_out), 32'(pc));
      chk(32'(vector_table_base_out), 32'(vtb));
      chk(32'(active_sp_out), 32'(sk ? user_stack_pointer : interrupt_stack_pointer));
      chk(32'(frame_base_out), 32'(fbm[bk]));
      chk(32'(static_base_out), 32'(sb));
      chk(addr_pair_out, {am[bk][1], am[bk][0]});
      chk({30'h0, bank_sel_out, stack_sel_out}, {30'h0, bk, sk});
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Sequence of tests
  // ------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    err_count++;
    results();
  end

  initial begin
    {pend, run, err_count, checks, seed} = {2'h0, 32'h0000_0000, 32'h0000_0000, 32'h0000_3cf2};
    mreset();
    for (int p = 0; p < 2; p++) begin
      repeat (16) begin
        op(1'b0, 1'b0, '0, '0);
        run = 1'b1;
      end
      rst_in <= 1'b0;
      for (int i = 0; i < 32; i++) op(1'b0, 1'b1, 5'(i), '0);
      $display("pass %0d reset and unmapped reads done", p);
      // Write the low data pair in bank one, swap back, confirm bank zero kept its contents
      op(1'b1, 1'b0, IDX_CPU_FLAGS, 32'h0000_0090);
      op(1'b1, 1'b0, IDX_DATA_PAIR_LOW, 32'h1234_5678);
      op(1'b0, 1'b1, IDX_DATA_PAIR_LOW, '0);
      op(1'b1, 1'b0, IDX_CPU_FLAGS, 32'h0000_0000);
      op(1'b0, 1'b1, IDX_DATA_PAIR_LOW, '0);
      op(1'b1, 1'b0, IDX_DATA_0_HIGH, 32'hffff_ffa5);
      op(1'b0, 1'b1, IDX_DATA_REG_0, '0);
      $display("pass %0d bank switch done", p);
      repeat (600) begin
        k = $random(seed);
        op(k[8], k[9] & ~k[8], k[4:0], $random(seed));
      end
      $display("pass %0d random traffic done", p);
      rst_in <= 1'b1;
    end
    repeat (2) op(1'b0, 1'b0, '0, '0);
    results();
  end
endmodule // cbr_regfile_tb
`default_nettype wire
